//--- rtl/scl_pkg.sv
// Constants and types shared by the start-up configuration loader
package scl_pkg;

    // Register map, byte addresses on the 2-byte address serial port
    localparam logic [15:0] BOOT_PAGE_CONFIG_ADDR = 16'h0014;
    localparam logic [15:0] RESET_CONTROL_ADDR    = 16'h0017;

    // Fields of boot_page_config
    localparam int OVERLAY_ENABLE_BIT   = 7;
    localparam int PAGE_OFFSET_LSB      = 3;
    localparam int PAGE_OFFSET_MSB      = 6;

    // Fields of reset_control
    localparam int CFG_DONE_BIT         = 7;
    localparam int GLOBAL_SOFT_RST_BIT  = 6;
    localparam int PLL_BUSY_LSB         = 3;
    localparam int PLL_RST_LSB          = 0;

    // Values after reset; the nonvolatile copy also ships as zero
    localparam logic [7:0] BOOT_PAGE_CONFIG_RST = 8'h00;
    localparam logic [7:0] RESET_CONTROL_RST    = 8'h00;

    // Strap levels of a three-level pin
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_MID  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    // Interface strap values
    localparam logic IF_I2C = 1'b0;
    localparam logic IF_SPI = 1'b1;

    // Page that boots into the low-power profile
    localparam logic [3:0] LOW_POWER_PAGE = 4'h3;

    // Register groups written by a loader: {dpll_frame_pin, drv, pll, osc}
    localparam logic [3:0] GRP_NONE    = 4'h0;
    localparam logic [3:0] GRP_ALL     = 4'hf;
    localparam logic [3:0] GRP_OVERLAY = 4'h7;

    // Start-up sequence, one-hot
    typedef enum logic [5:0] {
        ST_WAIT_PWR = 6'h01,
        ST_SAMPLE   = 6'h02,
        ST_ROM      = 6'h04,
        ST_OVERLAY  = 6'h08,
        ST_CAL      = 6'h10,
        ST_RUN      = 6'h20
    } scl_state_e;

endpackage

//--- rtl/scl_startup_config_loader.sv
// Start-up sequencer: strap capture, ROM page, overlay, PLL calibration
`timescale 1ns/100ps

// What the document asks of this block, of the host and of the system
// R1: Start the power-on configuration once the power-down pin is released high.
// R2: Sample the interface strap at POR: 0 selects I2C address pin, 1 SPI.
// R3: ROM page equals strap-pair page plus the stored page offset field.
// R4: With zero offset map LL0 LH1 HL2 HH3 LM4 ML5 MM6 MH7 HM8.
// R5: Page 3 boots low power, all PLLs off, all outputs disabled; an overlay boot clears low power and calibrates the PLLs.
// R6: Page offset comes from nonvolatile store, factory zero; ROM pages unwritable.
// R7: A global soft reset write restarts initialisation and PLL calibration.
// R8: Same calibration sequence after POR, global and per-PLL soft reset.
// R9: A per-PLL soft reset recalibrates and disturbs only that PLL's outputs.
// R10: The system keeps the PLL reference stable before calibration begins.
// R11: ROM-only boot loads the ROM page and skips the overlay.
// R12: Overlay boot rewrites only oscillator, PLL and output driver groups.
// R13: Host writes differing DPLL, frame-reference and pin settings after start.
// R14: After ROM boot the host may rewrite ROM-initialised registers; accepted.
// R15: Host should global-reset after changing PLL registers to realign dividers.
// R16: Outputs may be disrupted after global reset until each PLL relocks.
// R17: No soft reset needed for termination, driver, pin, status, DCO changes.
// R18: Global reset advised after zero-delay or frame-reference configuration.
// R19: Host uses one PLL's own reset when only that PLL changed.
// R20: Overlay enable is stored nonvolatile, factory zero; 1 applies overlay.
// R21: Strap levels are captured once at POR and then held.
module scl_startup_config_loader
    import scl_pkg::*;
#(
    parameter int NUM_PLL = 3
) (
    input  wire logic               ref_clk_i,             // 100 MHz clock
    input  wire logic               srst_i,                // Sync reset, high
    input  wire logic               power_down_n_pin_i,    // Power-down, low
    input  wire logic               interface_strap_pin_i, // I2C/SPI strap
    input  wire logic [1:0]         page_strap_high_i,     // Three-level strap
    input  wire logic [1:0]         page_strap_low_i,      // Three-level strap
    input  wire logic [7:0]         nv_boot_cfg_i,         // Stored boot byte
    input  wire logic               rom_done_i,            // ROM load finished
    input  wire logic               overlay_done_i,        // Overlay finished
    input  wire logic [NUM_PLL-1:0] pll_lock_i,            // PLL locked
    input  wire logic               reg_wr_i,              // Register write
    input  wire logic [15:0]        reg_addr_i,            // Register address
    input  wire logic [7:0]         reg_wdata_i,           // Write data
    output logic [7:0]              reg_rdata_o,           // Read data
    output logic                    spi_mode_o,            // 1 SPI, 0 I2C
    output logic                    addr_pin_is_i2c_o,     // Address pin role
    output logic [3:0]              rom_page_o,            // Selected page
    output logic                    low_power_o,           // Low-power boot
    output logic                    rom_load_req_o,        // ROM load request
    output logic                    overlay_load_req_o,    // Overlay request
    output logic [3:0]              load_groups_o,         // Groups written
    output logic [NUM_PLL-1:0]      pll_cal_start_o,       // Calibration pulse
    output logic [NUM_PLL-1:0]      pll_cal_busy_o,        // Calibrating
    output logic [NUM_PLL-1:0]      pll_out_enable_o,      // Outputs enabled
    output logic                    config_done_o          // Sequence finished
);

    // Base page of a strap pair before the offset is added
    function automatic logic [3:0] strap_page(input logic [1:0] hi,
                                              input logic [1:0] lo);
        logic [3:0] page;
        page = 4'h0;
        case ({hi, lo})
            {LVL_LOW, LVL_LOW}:   page = 4'h0;   // R4
            {LVL_LOW, LVL_HIGH}:  page = 4'h1;   // R4
            {LVL_HIGH, LVL_LOW}:  page = 4'h2;   // R4
            {LVL_HIGH, LVL_HIGH}: page = 4'h3;   // R4
            {LVL_LOW, LVL_MID}:   page = 4'h4;   // R4
            {LVL_MID, LVL_LOW}:   page = 4'h5;   // R4
            {LVL_MID, LVL_MID}:   page = 4'h6;   // R4
            {LVL_MID, LVL_HIGH}:  page = 4'h7;   // R4
            {LVL_HIGH, LVL_MID}:  page = 4'h8;   // R4
            default:              page = 4'h3;   // Any invalid code selects page 3
        endcase
        return page;
    endfunction

    scl_state_e           state;
    scl_state_e           next_state;
    logic                 spi_mode;
    logic                 next_spi_mode;
    logic [1:0]           strap_hi;
    logic [1:0]           next_strap_hi;
    logic [1:0]           strap_lo;
    logic [1:0]           next_strap_lo;
    logic [7:0]           boot_page_config;
    logic [7:0]           next_boot_page_config;
    logic [3:0]           rom_page;
    logic [3:0]           next_rom_page;
    logic                 low_power;
    logic                 next_low_power;
    logic [NUM_PLL-1:0]   cal_start;
    logic [NUM_PLL-1:0]   next_cal_start;
    logic [NUM_PLL-1:0]   cal_busy;
    logic [NUM_PLL-1:0]   next_cal_busy;
    logic [7:0]           rdata;
    logic [7:0]           next_rdata;

    logic                 wr_boot;
    logic                 wr_reset;
    logic                 global_rst_req;
    logic [NUM_PLL-1:0]   pll_rst_req;
    logic [NUM_PLL-1:0]   all_pll;

    // Register write decode; soft reset bits are strobes, never stored
    always_comb begin
        all_pll        = '1;
        wr_boot        = reg_wr_i && (reg_addr_i == BOOT_PAGE_CONFIG_ADDR);
        wr_reset       = reg_wr_i && (reg_addr_i == RESET_CONTROL_ADDR);
        global_rst_req = wr_reset && reg_wdata_i[GLOBAL_SOFT_RST_BIT];
        pll_rst_req    = wr_reset ? reg_wdata_i[PLL_RST_LSB +: NUM_PLL]
                                  : '0;
    end

    // Sequence and held configuration, next values
    always_comb begin
        next_state            = state;
        next_spi_mode         = spi_mode;
        next_strap_hi         = strap_hi;
        next_strap_lo         = strap_lo;
        next_boot_page_config = boot_page_config;
        next_rom_page         = rom_page;
        next_low_power        = low_power;
        next_cal_start        = '0;
        // A lock ends a calibration, a new start wins over that lock
        next_cal_busy         = cal_busy & ~pll_lock_i;
        if (wr_boot) begin
            next_boot_page_config = reg_wdata_i;                     // R14
        end
        case (state)
            ST_WAIT_PWR: begin
                if (power_down_n_pin_i) begin
                    next_state = ST_SAMPLE;                          // R1
                end
            end
            ST_SAMPLE: begin
                // Straps are caught once here and held; the stored byte is loaded here and host writes may replace it
                next_spi_mode         = interface_strap_pin_i;       // R2 R21
                next_strap_hi         = page_strap_high_i;           // R21
                next_strap_lo         = page_strap_low_i;            // R21
                next_boot_page_config = nv_boot_cfg_i;               // R6 R20
                next_state            = ST_ROM;
            end
            ST_ROM: begin
                // Offset added modulo 16; sums past the last page are
                // the host's problem, the ROM answers them as it will
                next_rom_page = strap_page(strap_hi, strap_lo)
                    + boot_page_config[PAGE_OFFSET_MSB:PAGE_OFFSET_LSB]; // R3
                if (rom_done_i) begin
                    next_low_power = (rom_page == LOW_POWER_PAGE);   // R5
                    if (boot_page_config[OVERLAY_ENABLE_BIT]) begin
                        next_state = ST_OVERLAY;                     // R20
                    end else if (rom_page == LOW_POWER_PAGE) begin
                        next_state = ST_RUN;                         // R5 R11
                    end else begin
                        next_state     = ST_CAL;                     // R11
                        next_cal_start = all_pll;                    // R8
                        next_cal_busy  = all_pll;                    // R8
                    end
                end
            end
            ST_OVERLAY: begin
                if (overlay_done_i) begin
                    // Overlay may bring PLLs up even on the low-power page
                    next_low_power = 1'b0;                           // R5
                    next_state     = ST_CAL;
                    next_cal_start = all_pll;                        // R8
                    next_cal_busy  = all_pll;                        // R8
                end
            end
            ST_CAL: begin
                if (cal_busy == '0) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // Only the addressed PLLs restart; the others keep running
                if (!low_power) begin
                    next_cal_start = pll_rst_req;                    // R9
                    next_cal_busy  = next_cal_busy | pll_rst_req;    // R9 R8
                end
            end
            default: begin
                next_state = ST_WAIT_PWR;
            end
        endcase
        // Global soft reset replays the sequence from the ROM load
        if (global_rst_req && (state != ST_WAIT_PWR)
                && (state != ST_SAMPLE)) begin
            next_state     = ST_ROM;                                 // R7
            next_cal_start = '0;
            next_cal_busy  = '0;
            next_low_power = 1'b0;
        end
        // Pulling the power-down pin low returns to the POR wait
        if (!power_down_n_pin_i) begin
            next_state     = ST_WAIT_PWR;                            // R1
            next_cal_start = '0;
            next_cal_busy  = '0;
            // Low-power flag must not outlive the page it came from
            next_low_power = 1'b0;                                   // R5
        end
    end

    // Read mux, registered so read data comes from a flop
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            BOOT_PAGE_CONFIG_ADDR: begin
                next_rdata = boot_page_config;
            end
            RESET_CONTROL_ADDR: begin
                next_rdata[CFG_DONE_BIT]                 = (state == ST_RUN);
                next_rdata[PLL_BUSY_LSB +: NUM_PLL]      = cal_busy;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state            <= ST_WAIT_PWR;
            spi_mode         <= IF_I2C;
            strap_hi         <= LVL_LOW;
            strap_lo         <= LVL_LOW;
            boot_page_config <= BOOT_PAGE_CONFIG_RST;
            rom_page         <= 4'h0;
            low_power        <= 1'b0;
            cal_start        <= '0;
            cal_busy         <= '0;
            rdata            <= RESET_CONTROL_RST;
        end else begin
            state            <= next_state;
            spi_mode         <= next_spi_mode;
            strap_hi         <= next_strap_hi;
            strap_lo         <= next_strap_lo;
            boot_page_config <= next_boot_page_config;
            rom_page         <= next_rom_page;
            low_power        <= next_low_power;
            cal_start        <= next_cal_start;
            cal_busy         <= next_cal_busy;
            rdata            <= next_rdata;
        end
    end

    // Outputs; the load requests are handshake levels held until done
    always_comb begin
        reg_rdata_o        = rdata;
        spi_mode_o         = spi_mode;                               // R2
        addr_pin_is_i2c_o  = (spi_mode == IF_I2C);                   // R2
        rom_page_o         = rom_page;
        low_power_o        = low_power;
        rom_load_req_o     = (state == ST_ROM) && (rom_page == next_rom_page);
        overlay_load_req_o = (state == ST_OVERLAY);
        load_groups_o      = GRP_NONE;
        if (state == ST_ROM) begin
            load_groups_o = GRP_ALL;                                 // R11
        end else if (state == ST_OVERLAY) begin
            load_groups_o = GRP_OVERLAY;                             // R12
        end
        pll_cal_start_o    = cal_start;
        pll_cal_busy_o     = cal_busy;
        // A PLL drives its outputs only when running and not calibrating
        pll_out_enable_o   = ((state == ST_RUN) && !low_power)
                             ? ~cal_busy : '0;                       // R5 R16 R9
        config_done_o      = (state == ST_RUN);
    end

endmodule

//--- testbench/scl_far_side_model.sv
// Model of ROM loader, overlay loader and analog PLL lock detectors
`timescale 1ns/100ps
module scl_far_side_model (
    input  wire logic       clk_i,       // Clock
    input  wire logic       srst_i,      // Sync reset
    input  wire logic       rom_req_i,   // ROM load request
    input  wire logic       ov_req_i,    // Overlay request
    input  wire logic [2:0] cal_start_i, // Calibration start pulses
    output logic            rom_done_o,  // ROM load finished
    output logic            ov_done_o,   // Overlay finished
    output logic [2:0]      lock_o       // PLL locked
);
    logic [2:0] rom_cnt, ov_cnt;
    logic [2:0] lk_cnt [3];
    // Loads take a few cycles; lock needs a settled reference first
    always_ff @(posedge clk_i) begin
        rom_cnt <= (srst_i || !rom_req_i) ? 3'h0 : rom_cnt + 3'h1;
        ov_cnt  <= (srst_i || !ov_req_i) ? 3'h0 : ov_cnt + 3'h1;
        for (int i = 0; i < 3; i++) begin
            if (srst_i || cal_start_i[i]) lk_cnt[i] <= 3'h0;
            else if (lk_cnt[i] != 3'h7) lk_cnt[i] <= lk_cnt[i] + 3'h1;
        end
    end
    // Done only while requested; lock drops at once on a new calibration
    assign rom_done_o = rom_req_i && (rom_cnt == 3'h3);
    assign ov_done_o  = ov_req_i && (ov_cnt == 3'h2);
    for (genvar g = 0; g < 3; g++) begin : g_lk
        assign lock_o[g] = !cal_start_i[g] && (lk_cnt[g] >= 3'h4);
    end
endmodule

//--- testbench/scl_loader_chk.sv
// Port assertions for the start-up configuration loader
`timescale 1ns/100ps
module scl_loader_chk
    import scl_pkg::*;
#(
    parameter int NUM_PLL = 3
) (
    input wire logic               ref_clk_i,          // Clock
    input wire logic               srst_i,             // Sync reset
    input wire logic               power_down_n_pin_i, // Power-down pin
    input wire logic               reg_wr_i,           // Write strobe
    input wire logic [15:0]        reg_addr_i,         // Address
    input wire logic [7:0]         reg_wdata_i,        // Write data
    input wire logic [7:0]         reg_rdata_o,        // Read data
    input wire logic               spi_mode_o,         // SPI selected
    input wire logic               addr_pin_is_i2c_o,  // Address pin role
    input wire logic [3:0]         rom_page_o,         // Page
    input wire logic               low_power_o,        // Low power boot
    input wire logic               rom_load_req_o,     // ROM request
    input wire logic               overlay_load_req_o, // Overlay request
    input wire logic [3:0]         load_groups_o,      // Groups written
    input wire logic [NUM_PLL-1:0] pll_cal_start_o,    // Cal start
    input wire logic [NUM_PLL-1:0] pll_cal_busy_o,     // Cal busy
    input wire logic [NUM_PLL-1:0] pll_out_enable_o,   // Output enable
    input wire logic               config_done_o       // Done
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // Write to the reset control byte
    logic wr_rst;
    assign wr_rst = reg_wr_i && (reg_addr_i == RESET_CONTROL_ADDR);

    a_addr_pin_role: assert property (addr_pin_is_i2c_o == !spi_mode_o)
        else $error("address pin role disagrees with interface mode");
    a_rom_groups: assert property (rom_load_req_o |->
        load_groups_o == GRP_ALL)
        else $error("ROM load not writing every group");
    a_overlay_groups: assert property (overlay_load_req_o |->
        load_groups_o == GRP_OVERLAY && !rom_load_req_o)
        else $error("overlay writes wrong groups");
    a_low_power_page: assert property (low_power_o |->
        rom_page_o == LOW_POWER_PAGE && pll_out_enable_o == '0)
        else $error("low power state with wrong page or outputs");
    a_start_sets_busy: assert property ($rose(pll_cal_busy_o[0]) |->
        pll_cal_start_o[0])
        else $error("busy rose without calibration start");
    a_global_restart: assert property (wr_rst && reg_wdata_i[6] &&
        config_done_o |=> !config_done_o ##0 pll_out_enable_o == '0)
        else $error("global soft reset did not restart");
    a_pll_reset_one: assert property (wr_rst && !reg_wdata_i[6] &&
        reg_wdata_i[1] && config_done_o && !low_power_o &&
        power_down_n_pin_i |=>
        pll_cal_start_o[1] && !pll_out_enable_o[1] && config_done_o)
        else $error("per PLL reset misbehaved");
    a_pll_reset_others: assert property (wr_rst && !reg_wdata_i[6] &&
        reg_wdata_i[2:0] == 3'h2 && pll_out_enable_o[0] &&
        pll_out_enable_o[2] && power_down_n_pin_i |=>
        pll_out_enable_o[0] && pll_out_enable_o[2])
        else $error("per PLL reset disturbed another PLL");
    a_power_low: assert property (!power_down_n_pin_i |=>
        !config_done_o && !rom_load_req_o)
        else $error("sequence active while powered down");
    a_unmapped_zero: assert property (
        reg_addr_i != BOOT_PAGE_CONFIG_ADDR &&
        reg_addr_i != RESET_CONTROL_ADDR |=> reg_rdata_o == 8'h00)
        else $error("unmapped address read non-zero");
endmodule

//--- testbench/tb.sv
// Self-checking bench for the start-up configuration loader
`timescale 1ns/100ps
module tb;
    import scl_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        srst_i = 1'b1, pwr = 1'b0, sif = 1'b0, reg_wr = 1'b0;
    logic [1:0]  st_hi = 2'h0, st_lo = 2'h0;
    logic [7:0]  nv_cfg = 8'h00, wdata = 8'h00, rdata;
    logic [15:0] addr = 16'h0000;
    logic        rom_done, ov_done, spi, i2c_pin, low_pw;
    logic        rom_req, ov_req, done;
    logic [3:0]  page, groups;
    logic [2:0]  cal_start, busy, out_en, lock;
    int          mismatches = 0;
    int          n_checks = 0;
    int          n_ov, ov_base;
    int          exp_pg [9] = '{0, 4, 1, 5, 6, 7, 2, 8, 3};

    always #5 ref_clk_i = ~ref_clk_i;
    // Count overlay request cycles since the last bench reset
    always @(posedge ref_clk_i) begin
        if (srst_i) n_ov <= 0;
        else if (ov_req === 1'b1) n_ov <= n_ov + 1;
    end

    scl_startup_config_loader #(.NUM_PLL(3)) dut (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .power_down_n_pin_i(pwr),
        .interface_strap_pin_i(sif), .page_strap_high_i(st_hi),
        .page_strap_low_i(st_lo), .nv_boot_cfg_i(nv_cfg),
        .rom_done_i(rom_done), .overlay_done_i(ov_done), .pll_lock_i(lock),
        .reg_wr_i(reg_wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .spi_mode_o(spi), .addr_pin_is_i2c_o(i2c_pin),
        .rom_page_o(page), .low_power_o(low_pw), .rom_load_req_o(rom_req),
        .overlay_load_req_o(ov_req), .load_groups_o(groups),
        .pll_cal_start_o(cal_start), .pll_cal_busy_o(busy),
        .pll_out_enable_o(out_en), .config_done_o(done));
    scl_far_side_model u_far (.clk_i(ref_clk_i), .srst_i(srst_i),
        .rom_req_i(rom_req), .ov_req_i(ov_req), .cal_start_i(cal_start),
        .rom_done_o(rom_done), .ov_done_o(ov_done), .lock_o(lock));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Bounded wait for done (which 0) or all outputs enabled (which 1)
    task automatic wait_hi(input int which);
        int i;
        for (i = 0; i < 300; i++) begin
            if ((which == 0) ? (done === 1'b1) : (out_en === 3'h7)) break;
            @(negedge ref_clk_i);
        end
        if (i == 300) begin
            mismatches++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge ref_clk_i);
        reg_wr = 1'b0;
    endtask
    // Read data lands one edge after the address
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge ref_clk_i);
        addr = a;
        @(negedge ref_clk_i);
        chk({8'h00, rdata}, {8'h00, e});
    endtask
    // Reset, hold power down, then release it and wait for the run state
    task automatic boot(input logic [1:0] h, input logic [1:0] l,
                        input logic [7:0] nv, input logic s);
        srst_i = 1'b1;
        pwr = 1'b0;
        st_hi = h;
        st_lo = l;
        nv_cfg = nv;
        sif = s;
        repeat (2) @(negedge ref_clk_i);
        srst_i = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        chk({rom_req, done}, 16'h0);
        pwr = 1'b1;
        wait_hi(0);
        st_hi = 2'h1; // Straps move after capture
        st_lo = 2'h0;
        sif = ~s;
        repeat (2) @(negedge ref_clk_i);
    endtask

    initial begin
        repeat (2) @(negedge ref_clk_i);
        srst_i = 1'b0;
        rd(RESET_CONTROL_ADDR, RESET_CONTROL_RST);
        rd(BOOT_PAGE_CONFIG_ADDR, BOOT_PAGE_CONFIG_RST);
        for (int i = 0; i < 9; i++) begin
            boot(2'(i / 3), 2'(i % 3), 8'h00, i[0]);
            chk(page, 16'(exp_pg[i]));
            chk({spi, i2c_pin}, {i[0], !i[0]});
            chk(low_pw, exp_pg[i] == 3);
            chk(out_en, (exp_pg[i] == 3) ? 3'h0 : 3'h7);
            chk(n_ov != 0, 1'b0);
        end
        boot(2'h0, 2'h0, 8'h90, 1'b0);
        chk(page, 4'h2);
        chk(n_ov != 0, 1'b1);
        rd(BOOT_PAGE_CONFIG_ADDR, 8'h90);
        wr(RESET_CONTROL_ADDR, 8'h02);
        chk({done, out_en}, 4'hd);
        chk({cal_start, busy}, 6'h12);
        wait_hi(1);
        ov_base = n_ov;
        wr(RESET_CONTROL_ADDR, 8'h40);
        chk({done, out_en}, 4'h0);
        wait_hi(0);
        chk({page, n_ov > ov_base}, 5'h05);
        rd(RESET_CONTROL_ADDR, 8'h80);
        wr(BOOT_PAGE_CONFIG_ADDR, 8'h08);
        rd(BOOT_PAGE_CONFIG_ADDR, 8'h08);
        // Replay picks up the offset the host just wrote
        wr(RESET_CONTROL_ADDR, 8'h40);
        wait_hi(0);
        chk(page, 4'h1);
        wr(16'h0015, 8'hff);
        rd(16'h0015, 8'h00);
        pwr = 1'b0;
        @(negedge ref_clk_i);
        chk(done, 1'b0);
        finish_test();
    end
endmodule

bind scl_startup_config_loader scl_loader_chk #(.NUM_PLL(NUM_PLL)) u_chk (
    .ref_clk_i, .srst_i, .power_down_n_pin_i, .reg_wr_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .spi_mode_o, .addr_pin_is_i2c_o, .rom_page_o,
    .low_power_o, .rom_load_req_o, .overlay_load_req_o, .load_groups_o,
    .pll_cal_start_o, .pll_cal_busy_o, .pll_out_enable_o, .config_done_o);
